// file: src/adf_consts.vh
`ifndef ADF_CONSTS_VH
`define ADF_CONSTS_VH
// log2 of the smallest oversampling ratio, field code 0
`define ADF_OSR_LOG2_BASE 4'd7
// sinc3 stage never decimates by more than 2^10
`define ADF_SINC3_LOG2_MAX 4'd10
`define ADF_OUT_W 24
`define ADF_OUT_W_LOG2 6'd24
`define ADF_ACC_W 36
`define ADF_CIC_W 31
`define ADF_CNT_W 14
// first conversions taken from the fast-settling path
`define ADF_FAST_CONVS 2'd2
// power mode field codes
`define ADF_PWR_VLP 2'h0
`define ADF_PWR_LP 2'h1
`define ADF_PWR_HR 2'h2
// nominal master clock per mode, in kHz
`define ADF_MCLK_HR_KHZ 8192
`define ADF_MCLK_LP_KHZ 4096
`define ADF_MCLK_VLP_KHZ 2048
`endif

// file: src/adf_sinc3.v
`default_nettype none
`include "adf_consts.vh"
module adf_sinc3 #(
  parameter CIC_W = `ADF_CIC_W
) (
  input wire core_clk,
  input wire rst_n,
  input wire clear,
  input wire sample,
  input wire dump,
  input wire bit_in,
  output reg [CIC_W-1:0] result_r,
  output reg result_valid_r
);
  reg [CIC_W-1:0] int1_r;
  reg [CIC_W-1:0] int2_r;
  reg [CIC_W-1:0] int3_r;
  reg [CIC_W-1:0] dly1_r;
  reg [CIC_W-1:0] dly2_r;
  reg [CIC_W-1:0] dly3_r;
  wire [CIC_W-1:0] comb1;
  wire [CIC_W-1:0] comb2;
  wire [CIC_W-1:0] comb3;
  // modular wrap in the integrators is harmless: combs undo it
  assign comb1 = int3_r - dly1_r;
  assign comb2 = comb1 - dly2_r;
  assign comb3 = comb2 - dly3_r;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int1_r <= {CIC_W{1'b0}};
      int2_r <= {CIC_W{1'b0}};
      int3_r <= {CIC_W{1'b0}};
      dly1_r <= {CIC_W{1'b0}};
      dly2_r <= {CIC_W{1'b0}};
      dly3_r <= {CIC_W{1'b0}};
      result_r <= {CIC_W{1'b0}};
      result_valid_r <= 1'b0;
    end else if (clear) begin
      int1_r <= {CIC_W{1'b0}};
      int2_r <= {CIC_W{1'b0}};
      int3_r <= {CIC_W{1'b0}};
      dly1_r <= {CIC_W{1'b0}};
      dly2_r <= {CIC_W{1'b0}};
      dly3_r <= {CIC_W{1'b0}};
      result_valid_r <= 1'b0;
    end else begin
      result_valid_r <= sample & dump;
      if (sample) begin
        int1_r <= int1_r + {{(CIC_W-1){1'b0}}, bit_in};
        int2_r <= int2_r + int1_r;
        int3_r <= int3_r + int2_r;
        if (dump) begin
          dly1_r <= int3_r;
          dly2_r <= comb1;
          dly3_r <= comb2;
          result_r <= comb3;
        end
      end
    end
  end
endmodule // adf_sinc3
`default_nettype wire

// file: src/adf_pair_buf.v
`default_nettype none
module adf_pair_buf #(
  parameter WIDTH = 25
) (
  input wire core_clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] slot0_r;
  reg [WIDTH-1:0] slot1_r;
  reg [1:0] count_r;
  wire push;
  wire pop;
  assign in_ready = (count_r != 2'd2);
  assign out_valid = (count_r != 2'd0);
  assign out_data = slot0_r;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot0_r <= {WIDTH{1'b0}};
      slot1_r <= {WIDTH{1'b0}};
      count_r <= 2'd0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count_r == 2'd0) begin
            slot0_r <= in_data;
          end else begin
            slot1_r <= in_data;
          end
          count_r <= count_r + 2'd1;
        end
        2'b01: begin
          slot0_r <= slot1_r;
          count_r <= count_r - 2'd1;
        end
        2'b11: begin
          if (count_r == 2'd1) begin
            slot0_r <= in_data;
          end else begin
            slot0_r <= slot1_r;
            slot1_r <= in_data;
          end
        end
        default: begin
          count_r <= count_r;
        end
      endcase
    end
  end
endmodule // adf_pair_buf
`default_nettype wire

// file: src/adf_decim_top.v
`default_nettype none
`include "adf_consts.vh"
module adf_decim_top #(
  parameter BUF_W = `ADF_OUT_W + 1
) (
  input wire core_clk,
  input wire rst_n,
  input wire [1:0] power_mode_field,
  input wire [2:0] oversampling_ratio_field,
  input wire use_crystal,
  input wire mod_bit_in,
  input wire ref_settled_in,
  input wire out_ready,
  output wire modulator_clock_out,
  output wire crystal_osc_enable,
  output wire high_resolution_mode,
  output wire low_power_mode,
  output wire very_low_power_mode,
  output wire out_valid,
  output wire [`ADF_OUT_W-1:0] out_data,
  output wire out_from_sinc3,
  output wire fast_path_active,
  output wire conv_running,
  output wire overrun
);
  localparam OUT_W = `ADF_OUT_W;
  localparam ACC_W = `ADF_ACC_W;
  localparam CIC_W = `ADF_CIC_W;
  localparam CNT_W = `ADF_CNT_W;

  // mask of the low l bits of the decimation counter
  function [CNT_W-1:0] low_mask;
    input [3:0] l;
    begin
      low_mask = ~({CNT_W{1'b1}} << l);
    end
  endfunction

  // map a sum whose full scale is 2^lf onto the output word
  function [OUT_W-1:0] scale_word;
    input [ACC_W-1:0] v;
    input [5:0] lf;
    reg [ACC_W-1:0] sh;
    begin
      sh = {ACC_W{1'b0}};
      if ((v >> lf) != {ACC_W{1'b0}}) begin
        scale_word = {OUT_W{1'b1}};
      end else begin
        if (lf >= `ADF_OUT_W_LOG2) begin
          sh = v >> (lf - `ADF_OUT_W_LOG2);
        end else begin
          sh = v << (`ADF_OUT_W_LOG2 - lf);
        end
        scale_word = sh[OUT_W-1:0];
      end
    end
  endfunction

  // sinc3 stage never decimates further; sinc1 takes the rest
  function [3:0] sinc3_log2;
    input [3:0] l;
    begin
      if (l > `ADF_SINC3_LOG2_MAX) begin
        sinc3_log2 = `ADF_SINC3_LOG2_MAX;
      end else begin
        sinc3_log2 = l;
      end
    end
  endfunction

  // one modulator bit widened to the ones counter
  function [CNT_W:0] bit_ext;
    input b;
    begin
      bit_ext = {{CNT_W{1'b0}}, b};
    end
  endfunction

  // one-hot {high_res, low_power, very_low_power}
  function [2:0] mode_flags;
    input [1:0] m;
    begin
      case (m)
        `ADF_PWR_VLP: mode_flags = 3'h1;
        `ADF_PWR_LP: mode_flags = 3'h2;
        // unassigned code 3 falls back to high resolution
        default: mode_flags = 3'h4;
      endcase
    end
  endfunction

  // pin inputs, two flops each
  reg bit_s1_r;
  reg bit_s2_r;
  reg ref_s1_r;
  reg ref_s2_r;
  reg mod_clk_r;
  reg run_r;
  reg [3:0] osr_l_r;
  reg [3:0] out_l_r;
  reg [CNT_W-1:0] mod_cnt_r;
  reg [CNT_W:0] ones_r;
  reg [CNT_W:0] fast_hold_r;
  reg end_d_r;
  reg [ACC_W-1:0] s1_acc_r;
  reg [1:0] conv_cnt_r;
  reg push_valid_r;
  reg [BUF_W-1:0] push_data_r;
  reg overrun_r;
  reg [1:0] mode_r;

  wire sample;
  wire [3:0] l3;
  wire [3:0] new_l;
  wire [5:0] full3;
  wire dump;
  wire conv_end;
  wire [CIC_W-1:0] s3_result;
  wire s3_valid;
  wire [ACC_W-1:0] s1_sum;
  wire use_fast;
  wire buf_in_ready;
  wire [BUF_W-1:0] buf_out;
  wire [3:0] l3_out;
  wire [2:0] mode_oh;
  wire [OUT_W-1:0] fast_word;
  wire [OUT_W-1:0] slow_word;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_s1_r <= 1'b0;
      bit_s2_r <= 1'b0;
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
    end else begin
      bit_s1_r <= mod_bit_in;
      bit_s2_r <= bit_s1_r;
      ref_s1_r <= ref_settled_in;
      ref_s2_r <= ref_s1_r;
    end
  end

  // divide by two; bit taken once per modulator period
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_clk_r <= 1'b0;
    end else begin
      mod_clk_r <= ~mod_clk_r;
    end
  end
  assign modulator_clock_out = mod_clk_r;
  assign sample = mod_clk_r & run_r;

  // crystal kept off unless it is the clock source
  assign crystal_osc_enable = use_crystal;

  // modes only scale analog bias; mode code 3 treated as high resolution
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= `ADF_PWR_HR;
    end else begin
      mode_r <= power_mode_field;
    end
  end
  assign mode_oh = mode_flags(mode_r);
  assign very_low_power_mode = mode_oh[0];
  assign low_power_mode = mode_oh[1];
  // rates follow whatever master clock arrives for the mode
  assign high_resolution_mode = mode_oh[2];

  // filter held clear until the reference is settled
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
    end else if (ref_s2_r) begin
      run_r <= 1'b1;
    end
  end
  assign conv_running = run_r;

  assign new_l = `ADF_OSR_LOG2_BASE + {1'b0, oversampling_ratio_field};
  assign l3 = sinc3_log2(osr_l_r);
  assign l3_out = sinc3_log2(out_l_r);
  assign full3 = {l3_out, 1'b0} + {2'b00, out_l_r};
  assign dump = ((mod_cnt_r & low_mask(l3)) == low_mask(l3));
  assign conv_end = (mod_cnt_r == low_mask(osr_l_r));

  // ratio changes only at a conversion boundary
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osr_l_r <= `ADF_OSR_LOG2_BASE;
      out_l_r <= `ADF_OSR_LOG2_BASE;
      mod_cnt_r <= {CNT_W{1'b0}};
      ones_r <= {(CNT_W+1){1'b0}};
      fast_hold_r <= {(CNT_W+1){1'b0}};
      end_d_r <= 1'b0;
    end else if (!run_r) begin
      osr_l_r <= new_l;
      out_l_r <= new_l;
      end_d_r <= 1'b0;
    end else begin
      end_d_r <= sample & conv_end;
      if (sample) begin
        if (conv_end) begin
          mod_cnt_r <= {CNT_W{1'b0}};
          osr_l_r <= new_l;
          out_l_r <= osr_l_r;
          fast_hold_r <= ones_r + bit_ext(bit_s2_r);
          ones_r <= {(CNT_W+1){1'b0}};
        end else begin
          mod_cnt_r <= mod_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
          ones_r <= ones_r + bit_ext(bit_s2_r);
        end
      end
    end
  end

  adf_sinc3 #(
    .CIC_W(CIC_W)
  ) u_sinc3 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(~run_r),
    .sample(sample),
    .dump(dump),
    .bit_in(bit_s2_r),
    .result_r(s3_result),
    .result_valid_r(s3_valid)
  );

  // sinc1 after sinc3 adds up the remaining factor of the ratio
  assign s1_sum = s1_acc_r + {{(ACC_W-CIC_W){1'b0}}, s3_result};
  assign use_fast = (conv_cnt_r < `ADF_FAST_CONVS);
  assign fast_path_active = use_fast;
  assign fast_word = scale_word({{(ACC_W-CNT_W-1){1'b0}}, fast_hold_r},
                                {2'b00, out_l_r});
  assign slow_word = scale_word(s1_sum, full3);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_acc_r <= {ACC_W{1'b0}};
      conv_cnt_r <= 2'd0;
      push_valid_r <= 1'b0;
      push_data_r <= {BUF_W{1'b0}};
    end else if (!run_r) begin
      s1_acc_r <= {ACC_W{1'b0}};
      push_valid_r <= 1'b0;
    end else begin
      push_valid_r <= s3_valid & end_d_r;
      if (s3_valid) begin
        if (end_d_r) begin
          s1_acc_r <= {ACC_W{1'b0}};
          if (use_fast) begin
            push_data_r <= {1'b0, fast_word};
            conv_cnt_r <= conv_cnt_r + 2'd1;
          end else begin
            push_data_r <= {1'b1, slow_word};
          end
        end else begin
          s1_acc_r <= s1_sum;
        end
      end
    end
  end

  // settling words are not gated; host drops them
  adf_pair_buf #(
    .WIDTH(BUF_W)
  ) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(push_valid_r),
    .in_ready(buf_in_ready),
    .in_data(push_data_r),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(buf_out)
  );
  assign out_data = buf_out[OUT_W-1:0];
  assign out_from_sinc3 = buf_out[OUT_W];

  // modulator cannot stall; a word with no room is dropped and sets the sticky overrun flag
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_r <= 1'b0;
    end else if (push_valid_r & ~buf_in_ready) begin
      overrun_r <= 1'b1;
    end
  end
  assign overrun = overrun_r;
endmodule // adf_decim_top
`default_nettype wire

// file: tb/adf_decim_top_monitor.sv
`default_nettype none
`include "adf_consts.vh"
module adf_decim_top_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] power_mode_field,
  input wire logic [2:0] oversampling_ratio_field,
  input wire logic use_crystal,
  input wire logic mod_bit_in,
  input wire logic ref_settled_in,
  input wire logic out_ready,
  input wire logic modulator_clock_out,
  input wire logic crystal_osc_enable,
  input wire logic high_resolution_mode,
  input wire logic low_power_mode,
  input wire logic very_low_power_mode,
  input wire logic out_valid,
  input wire logic [`ADF_OUT_W-1:0] out_data,
  input wire logic out_from_sinc3,
  input wire logic fast_path_active,
  input wire logic conv_running,
  input wire logic overrun
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // first edge after release still shows the reset value
  mclk_half_a: assert property (
    $past(rst_n) |-> modulator_clock_out != $past(modulator_clock_out))
    else $error("modulator clock did not toggle");
  mode_decode_a: assert property (
    $past(rst_n) |-> {high_resolution_mode, low_power_mode,
    very_low_power_mode} == (($past(power_mode_field) >= 2'h2) ? 3'h4 :
    ($past(power_mode_field) == 2'h1) ? 3'h2 : 3'h1))
    else $error("power mode decode wrong");
  xtal_enable_a: assert property (
    crystal_osc_enable == use_crystal)
    else $error("oscillator enable differs from source select");
  no_early_data_a: assert property (
    !conv_running |-> !out_valid)
    else $error("word before reference settled");
  run_sticky_a: assert property (
    conv_running |=> conv_running)
    else $error("conversion run dropped");
  run_cause_a: assert property (
    $rose(conv_running) |-> $past(ref_settled_in, 2))
    else $error("run started without settled reference");
  fast_ends_a: assert property (
    !fast_path_active |=> !fast_path_active)
    else $error("fast path came back");
  sinc3_after_fast_a: assert property (
    out_valid && out_from_sinc3 |-> !fast_path_active)
    else $error("sinc3 word while fast path active");
  word_hold_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data) &&
    $stable(out_from_sinc3))
    else $error("stalled word changed");
  overrun_sticky_a: assert property (
    overrun |=> overrun)
    else $error("overrun flag cleared");
endmodule // adf_decim_top_monitor
bind adf_decim_top adf_decim_top_monitor mon (.core_clk, .rst_n,
  .power_mode_field, .oversampling_ratio_field, .use_crystal, .mod_bit_in,
  .ref_settled_in, .out_ready, .modulator_clock_out, .crystal_osc_enable,
  .high_resolution_mode, .low_power_mode, .very_low_power_mode, .out_valid,
  .out_data, .out_from_sinc3, .fast_path_active, .conv_running, .overrun);
`default_nettype wire

// file: tb/adf_mod_model.sv
`default_nettype none
module adf_mod_model (
  input wire logic mod_clk,
  input wire logic level,
  output logic mod_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // bit moves only on modulator clock edges, so never mid-sample
  initial mod_bit = 1'b0;
  always @(posedge mod_clk) mod_bit <= level;
endmodule // adf_mod_model
`default_nettype wire

// file: tb/tb_adf_decim_top.sv
`default_nettype none
`include "adf_consts.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  miscompares++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); \
  end end
module tb_adf_decim_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] power_mode_field = 2'h0;
  logic [2:0] oversampling_ratio_field = 3'h0;
  logic use_crystal = 1'b0;
  logic mod_bit_in;
  logic ref_settled_in = 1'b0;
  logic out_ready = 1'b0;
  logic level = 1'b0;
  logic stall = 1'b0;
  wire modulator_clock_out, crystal_osc_enable, high_resolution_mode;
  wire low_power_mode, very_low_power_mode, out_valid, out_from_sinc3;
  wire fast_path_active, conv_running, overrun;
  wire [`ADF_OUT_W-1:0] out_data;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  time tw;
  logic [23:0] w;
  logic s3;
  logic [2:0] mode_got;

  adf_decim_top dut (.core_clk, .rst_n, .power_mode_field,
    .oversampling_ratio_field, .use_crystal, .mod_bit_in, .ref_settled_in,
    .out_ready, .modulator_clock_out, .crystal_osc_enable,
    .high_resolution_mode, .low_power_mode, .very_low_power_mode,
    .out_valid, .out_data, .out_from_sinc3, .fast_path_active,
    .conv_running, .overrun);
  adf_mod_model model (.mod_clk(modulator_clock_out), .level(level),
    .mod_bit(mod_bit_in));

  // stand-in master clock; all rates scale with it
  always #5 core_clk = ~core_clk;

  function automatic logic [2:0] mode_exp(logic [1:0] pm);
    return pm[1] ? 3'h4 : (pm[0] ? 3'h2 : 3'h1);
  endfunction

  function automatic logic [23:0] exp_word(logic l);
    return l ? 24'hffffff : 24'h0;
  endfunction

  task automatic give_verdict();
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // longest ratio needs ~33k cycles for one word
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic do_reset();
    @(negedge core_clk);
    rst_n = 1'b0;
    ref_settled_in = 1'b0;
    out_ready = 1'b0;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
  endtask

  // head is read at the falling edge, popped at the next rising edge
  task automatic get_word(output logic [23:0] d, output logic v3);
    int n;
    logic hit;
    n = 0;
    do begin
      @(negedge core_clk);
      out_ready = stall ? 1'($urandom) : 1'b1;
      d = out_data;
      v3 = out_from_sinc3;
      hit = (out_valid === 1'b1) && out_ready;
      if (hit) tw = $time;
      n++;
      @(posedge core_clk);
    end while (!hit && n < 40000);
    if (!hit) miscompares++;
  endtask

  initial begin
    int code;
    time t1;
    void'($urandom(22093));
    do_reset();
    repeat (40) @(negedge core_clk);
    `CHK(conv_running, 1'b0)
    `CHK(out_valid, 1'b0)
    for (code = 0; code < 8; code++) begin
      if (code > 0) do_reset();
      oversampling_ratio_field = 3'(code);
      // every mode code once, then random
      power_mode_field = (code < 4) ? 2'(code) : 2'($urandom);
      use_crystal = 1'($urandom);
      level = (code == 4) ? 1'b1 : 1'($urandom);
      repeat (2) @(negedge core_clk);
      mode_got = {high_resolution_mode, low_power_mode, very_low_power_mode};
      `CHK(mode_got, mode_exp(power_mode_field))
      `CHK(crystal_osc_enable, use_crystal)
      ref_settled_in = 1'b1;
      get_word(w, s3);
      t1 = tw;
      `CHK(w, exp_word(level))
      `CHK(s3, 1'b0)
      if (code < 5) begin
        get_word(w, s3);
        `CHK((tw - t1) / 64'ha, 64'h1 << (8 + code))
        `CHK(s3, 1'b0)
        // third word: settled sinc3 at 1024 followed by sinc1 of 2
        if (code == 4) begin
          get_word(w, s3);
          `CHK(s3, 1'b1)
          `CHK(w, exp_word(level))
        end
      end
    end
    // fill the buffer with the consumer stalled, then drain it
    do_reset();
    oversampling_ratio_field = 3'h0;
    level = 1'b1;
    ref_settled_in = 1'b1;
    stall = 1'b1;
    for (int i = 0; i < 2000 && overrun !== 1'b1; i++) @(negedge core_clk);
    `CHK(overrun, 1'b1)
    for (code = 0; code < 8; code++) begin
      get_word(w, s3);
      `CHK(s3, 1'(code > 1))
      // early sinc3 words are unsettled and skipped
      if (code > 4) `CHK(w, 24'hffffff)
    end
    `CHK(fast_path_active, 1'b0)
    `CHK(overrun, 1'b1)
    give_verdict();
  end
endmodule // tb_adf_decim_top
`default_nettype wire
